// *** mwp_consts.svh ***
// constants for the microword parity error status block
`ifndef MWP_CONSTS_SVH
`define MWP_CONSTS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define MWP_ADDR_CES      8'h0C
`define MWP_ADDR_STACK    8'h20
`define MWP_ADDR_MATCH    8'h84
`define MWP_ADDR_TRAPPED  8'hC8
`define MWP_ADDR_CTRL     8'hD0
`define MWP_ADDR_STATUS   8'hD4

// ****************************************
// field positions
// ****************************************
`define MWP_CES_NESTED    16
`define MWP_CES_SUMMARY   15
`define MWP_CES_GROUP_LSB 12
`define MWP_CES_COND_LSB  7
`define MWP_CES_TRAP_LSB  4
`define MWP_CES_PERF      3
`define MWP_CES_AST_LSB   1
`define MWP_CTRL_STOP     0
`define MWP_CTRL_WIDE     1
`define MWP_CTRL_OPT      2
`define MWP_ADR_SOURCE    12
`define MWP_ADR_SEL_1K    10
`define MWP_ADR_SEL_2K    11

// ****************************************
// sizes and reset values
// ****************************************
`define MWP_GROUPS        3
`define MWP_GROUP_BITS    32
`define MWP_STACK_DEPTH   8
`define MWP_RST_CTRL      3'h0
`define MWP_RST_MATCH     16'h0000
`define MWP_RST_WORD      32'h0000_0000

`endif

// *** mwp_pkg.sv ***
// types shared by the microword parity error status block
package mwp_pkg;

	// arithmetic trap codes held in the error status register
	typedef enum logic [2:0] {
		MWP_TRAP_NONE     = 3'h0,
		MWP_TRAP_INT_OVF  = 3'h1,
		MWP_TRAP_INT_DIV0 = 3'h2,
		MWP_TRAP_FLT_OVF  = 3'h3,
		MWP_TRAP_FLT_DIV0 = 3'h4,
		MWP_TRAP_FLT_UNF  = 3'h5,
		MWP_TRAP_DEC_OVF  = 3'h6,
		MWP_TRAP_DEC_DIV0 = 3'h7
	} mwp_trap_code_t;

	typedef logic [95:0] mwp_word_t;
	typedef logic [15:0] mwp_uaddr_t;

endpackage : mwp_pkg

// *** mwp_parity_check.sv ***
// per-group even parity checker on the control store microword
`timescale 1ns/1ps
`include "mwp_consts.svh"

module mwp_parity_check (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             reset_n,
	// fetch from the control store
	input  wire logic             fetch,
	input  wire mwp_pkg::mwp_word_t word,
	input  wire logic [2:0]       parity,
	input  wire mwp_pkg::mwp_uaddr_t address,
	// result, one cycle after the fetch
	output logic [2:0]            errorGroup,
	output mwp_pkg::mwp_uaddr_t   errorAddress
);
	import mwp_pkg::*;

	typedef struct packed {
		logic [2:0] errorGroup;
		mwp_uaddr_t errorAddress;
	} mwp_chk_state_t;

	mwp_chk_state_t state;
	mwp_chk_state_t next_state;
	logic [2:0]     oddGroup;

	// ****************************************
	// parity per group
	// ****************************************
	// each 32-bit group plus its parity bit must hold an even count
	genvar g;
	generate
		for (g = 0; g < `MWP_GROUPS; g = g + 1) begin : gen_group
			assign oddGroup[g] = ^{word[g*`MWP_GROUP_BITS +: `MWP_GROUP_BITS], parity[g]}; // see RL1 RL2 RL3
		end
	endgenerate

	// next state: a pulse per failing group, address of the fetch
	always_comb begin
		next_state = state;
		next_state.errorGroup = fetch ? oddGroup : 3'h0;
		if (fetch) begin
			next_state.errorAddress = address;
		end
	end

	// state register
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign errorGroup   = state.errorGroup;
	assign errorAddress = state.errorAddress;

endmodule : mwp_parity_check

// *** mwp_micro_stack.sv ***
// micro-address stack, push on write and pop on read
`timescale 1ns/1ps
`include "mwp_consts.svh"

module mwp_micro_stack (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               reset_n,
	// stack control
	input  wire logic               push,
	input  wire logic               pop,
	input  wire mwp_pkg::mwp_uaddr_t pushData,
	output mwp_pkg::mwp_uaddr_t     top
);
	import mwp_pkg::*;

	typedef struct packed {
		logic [`MWP_STACK_DEPTH-1:0][15:0] entry;
	} mwp_stk_state_t;

	mwp_stk_state_t state;
	mwp_stk_state_t next_state;

	// ****************************************
	// shift stack: entry 0 is the top
	// ****************************************
	// a push drops the deepest entry; a pop refills the bottom with zero
	genvar e;
	generate
		for (e = 0; e < `MWP_STACK_DEPTH; e = e + 1) begin : gen_entry
			always_comb begin
				if (push) begin
					next_state.entry[e] = (e == 0) ? pushData : state.entry[(e == 0) ? 0 : e - 1];
				end else if (pop) begin
					next_state.entry[e] = (e == `MWP_STACK_DEPTH - 1) ? 16'h0000
						: state.entry[(e == `MWP_STACK_DEPTH - 1) ? e : e + 1];
				end else begin
					next_state.entry[e] = state.entry[e];
				end
			end
		end
	endgenerate

	// state register
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign top = state.entry[0];

endmodule : mwp_micro_stack

// *** mwp_error_status.sv ***
// microword parity error status, trap request, micro stack and micro-PC match
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "mwp_consts.svh"

// Behaviour
// RL1: each 96-bit microword is checked as three separate 32-bit parity groups.
// RL2: a group plus its parity bit must hold an even count of ones.
// RL3: bits 31:0 report in bit 12, 63:32 in bit 13, 95:64 in bit 14.
// RL4: a failing group sets its flag in error status bits 14:12.
// RL5: error status bit 15 reads one while any group flag is set.
// RL6: trapped address bit 12 is zero for fixed store, one for writable.
// RL7: with a 1K lowest board, bit 10 picks primary or optional store.
// RL8: with a 2K lowest board, bit 11 picks primary or optional store.
// RL9: the parity error indication halts translation buffer operations.
// RL10: a parity error raises a microcode trap request.
// RL11: a disabled optional store access yields an all-ones microword.
// RL12: writable store is written only by the console, never read back.
// RL13: arithmetic trap code field in bits 6:4 uses the eight listed codes.
// RL14: reading the stack port pops the top; writing pushes the address.
// RL15: a sync trigger pulses when the micro-PC equals the match register.
// RL16: logic exists to halt the CPU at a chosen micro-address.
// RL17: stop-on-match set halts on the match address; clearing it disables.
// RL18: the first trapped address stays held until the error flags clear.
// RL19: error status bits 2:1 hold the asynchronous trap level.
// RL20: fourteen indicators show micro-PC bits 12:0 and the stall state.
// RL21: group and summary flags hold until a clearing write or CPU init.
module mwp_error_status (
	// clock and reset
	input  wire logic                   clk,
	input  wire logic                   reset_n,
	// wishbone classic slave
	input  wire logic                   wbCyc,
	input  wire logic                   wbStb,
	input  wire logic                   wbWe,
	input  wire logic [7:0]             wbAdr,
	input  wire logic [3:0]             wbSel,
	input  wire logic [31:0]            wbDatIn,
	output logic [31:0]                 wbDatOut,
	output logic                        wbAck,
	// control store fetch
	input  wire logic                   fetch,
	input  wire mwp_pkg::mwp_uaddr_t    microProgramCounter,
	input  wire mwp_pkg::mwp_word_t     storeWord,
	input  wire logic [2:0]             storeParity,
	// cpu side events
	input  wire logic                   cpuInit,
	input  wire logic                   stall,
	input  wire logic                   arithTrapLoad,
	input  wire mwp_pkg::mwp_trap_code_t arithTrapCode,
	input  wire logic                   condLoad,
	input  wire logic [4:0]             condBits,
	input  wire logic                   consoleStoreWrite,
	// outputs to the processor
	output logic                        trapRequest,
	output logic                        translationBufferHalt,
	output logic                        syncTrigger,
	output logic                        cpuHalt,
	output logic [1:0]                  asyncTrapLevel,
	output logic [13:0]                 indicator,
	output logic                        storeWriteEnable,
	output mwp_pkg::mwp_uaddr_t         trappedMicroAddress
);
	import mwp_pkg::*;

	typedef struct packed {
		logic           ack;
		logic [31:0]    rdata;
		logic [2:0]     groupErr;
		logic           nested;
		logic [4:0]     cond;
		mwp_trap_code_t trapCode;
		logic           perfEnable;
		logic [1:0]     astLevel;
		mwp_uaddr_t     matchAddr;
		logic [2:0]     ctrl;
		mwp_uaddr_t     trappedAddr;
		logic           trapReq;
		logic           syncPulse;
		logic           halted;
		logic [13:0]    indicator;
		logic           storeWrite;
	} mwp_state_t;

	mwp_state_t  state;
	mwp_state_t  next_state;

	logic        request;
	logic        busWrite;
	logic        busRead;
	logic [31:0] byteMask;
	logic [31:0] cesValue;
	logic [31:0] cesMerged;
	logic [31:0] readValue;
	logic        summary;
	logic        optAccess;
	logic        optDisabled;
	mwp_word_t   checkedWord;
	logic [2:0]  checkedParity;
	logic [2:0]  errPulse;
	mwp_uaddr_t  errAddress;
	logic        matchHit;
	logic        stackPush;
	logic        stackPop;
	mwp_uaddr_t  stackTop;
	logic [2:0]  errClear;

	// ****************************************
	// wishbone decode
	// ****************************************
	// a new request is taken in the cycle before ack is given
	assign request  = wbCyc && wbStb && !state.ack;
	assign busWrite = request && wbWe;
	assign busRead  = request && !wbWe;
	assign byteMask = {{8{wbSel[3]}}, {8{wbSel[2]}}, {8{wbSel[1]}}, {8{wbSel[0]}}};

	// stack port side effects happen on the accepting edge
	assign stackPop  = busRead && (wbAdr == `MWP_ADDR_STACK); // see RL14
	assign stackPush = busWrite && (wbAdr == `MWP_ADDR_STACK) && (wbSel[1:0] != 2'h0); // see RL14

	// ****************************************
	// error status register image
	// ****************************************
	// summary is live from the group flags
	assign summary = |state.groupErr; // see RL5

	assign cesValue = {15'h0000, state.nested, summary, state.groupErr, state.cond,
		state.trapCode, state.perfEnable, state.astLevel, 1'b0}; // see RL13 RL19
	assign cesMerged = (cesValue & ~byteMask) | (wbDatIn & byteMask);
	// writing a one to a group bit clears that flag
	assign errClear = (busWrite && (wbAdr == `MWP_ADDR_CES))
		? (wbDatIn[`MWP_CES_GROUP_LSB +: 3] & byteMask[`MWP_CES_GROUP_LSB +: 3]) : 3'h0;

	// ****************************************
	// store selection and microword checking
	// ****************************************
	// writable-store address whose select bit depends on lowest board size
	assign optAccess = microProgramCounter[`MWP_ADR_SOURCE]
		&& (state.ctrl[`MWP_CTRL_WIDE] ? microProgramCounter[`MWP_ADR_SEL_2K]
		: microProgramCounter[`MWP_ADR_SEL_1K]); // see RL7 RL8
	assign optDisabled = optAccess && !state.ctrl[`MWP_CTRL_OPT];

	// an optional store that is not enabled puts all ones on the bus
	assign checkedWord   = optDisabled ? {96{1'b1}} : storeWord; // see RL11
	assign checkedParity = optDisabled ? 3'h7 : storeParity; // see RL11

	// result one cycle after the fetch
	mwp_parity_check u_check (
		.clk          (clk),
		.reset_n      (reset_n),
		.fetch        (fetch),
		.word         (checkedWord),
		.parity       (checkedParity),
		.address      (microProgramCounter),
		.errorGroup   (errPulse),
		.errorAddress (errAddress)
	);

	mwp_micro_stack u_stack (
		.clk      (clk),
		.reset_n  (reset_n),
		.push     (stackPush),
		.pop      (stackPop),
		.pushData (wbDatIn[15:0]),
		.top      (stackTop)
	);

	// match of the current fetch against the match register
	assign matchHit = fetch && (microProgramCounter == state.matchAddr);

	// ****************************************
	// read multiplexer
	// ****************************************
	// unmapped offsets read as zero
	always_comb begin
		unique case (wbAdr)
			`MWP_ADDR_CES:     readValue = cesValue;
			`MWP_ADDR_STACK:   readValue = {16'h0000, stackTop}; // see RL14
			`MWP_ADDR_MATCH:   readValue = {16'h0000, state.matchAddr};
			`MWP_ADDR_TRAPPED: readValue = {16'h0000, state.trappedAddr};
			`MWP_ADDR_CTRL:    readValue = {29'h0000_0000, state.ctrl};
			`MWP_ADDR_STATUS:  readValue = {30'h0000_0000, summary, state.halted};
			default:           readValue = `MWP_RST_WORD;
		endcase
	end

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		next_state = state;
		next_state.ack = request;
		if (busRead) begin
			next_state.rdata = readValue;
		end

		// group flags: a new error wins over a clear in the same cycle
		next_state.groupErr = (cpuInit ? 3'h0 : (state.groupErr & ~errClear)) | errPulse; // see RL4 RL21

		// first error keeps its address until the flags are cleared
		if ((errPulse != 3'h0) && (state.groupErr == 3'h0)) begin
			next_state.trappedAddr = errAddress; // see RL6 RL18
		end
		next_state.trapReq = |errPulse; // see RL10

		// software fields of the error status register
		if (busWrite && (wbAdr == `MWP_ADDR_CES)) begin
			next_state.nested     = cesMerged[`MWP_CES_NESTED];
			next_state.cond       = cesMerged[`MWP_CES_COND_LSB +: 5];
			next_state.trapCode   = mwp_trap_code_t'(cesMerged[`MWP_CES_TRAP_LSB +: 3]); // see RL13
			next_state.perfEnable = cesMerged[`MWP_CES_PERF];
			next_state.astLevel   = cesMerged[`MWP_CES_AST_LSB +: 2]; // see RL19
		end
		// hardware loads take precedence over a software write
		if (condLoad) begin
			next_state.cond = condBits;
		end
		if (arithTrapLoad) begin
			next_state.trapCode = arithTrapCode; // see RL13
		end
		if (cpuInit) begin
			next_state.trapCode = MWP_TRAP_NONE;
		end

		// match and control registers
		if (busWrite && (wbAdr == `MWP_ADDR_MATCH)) begin
			next_state.matchAddr = cesMergedMatch(state.matchAddr, wbDatIn, byteMask);
		end
		if (busWrite && (wbAdr == `MWP_ADDR_CTRL) && wbSel[0]) begin
			next_state.ctrl = wbDatIn[2:0];
		end

		// sync pulse and stop-on-match halt
		next_state.syncPulse = matchHit; // see RL15
		if (!next_state.ctrl[`MWP_CTRL_STOP]) begin
			next_state.halted = 1'b0; // see RL17
		end else if (matchHit) begin
			next_state.halted = 1'b1; // see RL16 RL17
		end

		// indicators and console-only store write strobe
		next_state.indicator  = {stall, microProgramCounter[12:0]}; // see RL20
		next_state.storeWrite = consoleStoreWrite; // see RL12
	end

	// merge a 16-bit register with the written bytes
	function automatic mwp_uaddr_t cesMergedMatch(input mwp_uaddr_t old,
		input logic [31:0] data, input logic [31:0] mask);
		cesMergedMatch = (old & ~mask[15:0]) | (data[15:0] & mask[15:0]);
	endfunction : cesMergedMatch

	// state register
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state           <= '0;
			state.ctrl      <= `MWP_RST_CTRL;
			state.matchAddr <= `MWP_RST_MATCH;
		end else begin
			state <= next_state;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign wbAck                 = state.ack;
	assign wbDatOut              = state.rdata;
	assign trapRequest           = state.trapReq;
	assign translationBufferHalt = summary; // see RL9
	assign syncTrigger           = state.syncPulse;
	assign cpuHalt               = state.halted;
	assign asyncTrapLevel        = state.astLevel;
	assign indicator             = state.indicator;
	assign storeWriteEnable      = state.storeWrite;
	assign trappedMicroAddress   = state.trappedAddr;

	// ****************************************
	// assertions
	// ****************************************
	// all properties run on the block clock and sleep in reset
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	// error path: flags, trap request, buffer halt, captured address
	group_flag_a: assert property (fetch && optDisabled |=> ##1 (state.groupErr == 3'h7)) // see RL11
		else $error("disabled optional store did not flag all groups");
	flag_set_a: assert property ((errPulse != 3'h0) |=> ((state.groupErr & $past(errPulse)) == $past(errPulse))) // see RL4
		else $error("group error flag not set");
	summary_bit_a: assert property (wbAck && $past(busRead && wbAdr == `MWP_ADDR_CES) |-> (wbDatOut[15] == |wbDatOut[14:12])) // see RL5
		else $error("summary bit disagrees with group flags");
	trap_req_a: assert property ((errPulse != 3'h0) // see RL10
		|=> trapRequest ##1 (!trapRequest || $past(errPulse != 3'h0)))
		else $error("trap request not pulsed");
	tb_halt_a: assert property ((errPulse != 3'h0) |=> translationBufferHalt) // see RL9
		else $error("translation buffer not halted");

	flag_hold_a: assert property (state.groupErr[0] && !cpuInit && !errClear[0] |=> state.groupErr[0]) // see RL21
		else $error("group flag lost without clear");
	first_addr_a: assert property ((errPulse != 3'h0) && (state.groupErr == 3'h0)
		|=> (trappedMicroAddress == $past(errAddress))) // see RL18
		else $error("trapped address not captured");
	held_addr_a: assert property ((state.groupErr != 3'h0) && !cpuInit && (errClear == 3'h0)
		|=> $stable(trappedMicroAddress)) // see RL18
		else $error("trapped address overwritten");

	// micro-PC match, stop-on-match halt and indicators
	sync_pulse_a: assert property (matchHit |=> syncTrigger) // see RL15
		else $error("sync trigger missing on match");
	stop_halt_a: assert property (matchHit && state.ctrl[0] && !busWrite |=> cpuHalt) // see RL17
		else $error("cpu did not halt on match");
	stop_clear_a: assert property (!state.ctrl[0] |-> !cpuHalt) // see RL17
		else $error("halt active with stop disabled");
	indicator_a: assert property (##1 indicator == {$past(stall), $past(microProgramCounter[12:0])}) // see RL20
		else $error("indicators do not follow micro-PC");

	// bus answer, clears and loaded fields
	ack_pulse_a: assert property (wbAck |=> !wbAck)
		else $error("ack held too long");
	flag_clear_a: assert property (errClear[0] && !errPulse[0] // see RL21
		|=> !state.groupErr[0])
		else $error("flag not cleared");
	init_clear_a: assert property (cpuInit && (errPulse == 3'h0) // see RL21
		|=> (state.groupErr == 3'h0))
		else $error("flags kept over init");
	trap_load_a: assert property (arithTrapLoad && !cpuInit // see RL13
		|=> (state.trapCode == $past(arithTrapCode)))
		else $error("trap code not loaded");

	push_top_a: assert property (stackPush // see RL14
		|=> (stackTop == $past(wbDatIn[15:0])))
		else $error("push not on top");
	pop_value_a: assert property (stackPop // see RL14
		|=> (wbDatOut[15:0] == $past(stackTop)))
		else $error("pop value wrong");

	error_seen_c: cover property ((errPulse != 3'h0) ##1 trapRequest);
	sync_seen_c:  cover property (matchHit ##1 syncTrigger);
	halt_seen_c:  cover property (cpuHalt ##[1:16] !cpuHalt);
	opt_fault_c:  cover property (fetch && optDisabled);
	stack_pop_c:  cover property (stackPush ##[1:20] stackPop);

endmodule : mwp_error_status

// *** mwp_store_model.sv ***
// control store boards model driving the microword bus
`timescale 1ns/1ps

module mwp_store_model (
	// clock and reset
	input  wire logic                clk,
	input  wire logic                reset_n,
	// fetch request from the bench
	input  wire logic                request,
	input  wire mwp_pkg::mwp_uaddr_t reqAddress,
	input  wire logic [2:0]          badGroups,
	input  wire logic [2:0]          ctrl,
	// microword bus
	output logic                     fetch,
	output mwp_pkg::mwp_uaddr_t      microProgramCounter,
	output mwp_pkg::mwp_word_t       storeWord,
	output logic [2:0]               storeParity
);
	import mwp_pkg::*;

	// ****************************************
	// store read
	// ****************************************
	mwp_word_t pattern;
	logic      optSelect;

	// word and select from the request
	assign pattern   = {3{16'hA5C3, reqAddress}};
	assign optSelect = reqAddress[12] & (ctrl[1] ? reqAddress[11] : reqAddress[10]);

	// word follows the address, or is all ones with odd parity from a disabled optional store; else parity is even per group unless a group is spoiled
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			fetch               <= 1'b0;
			microProgramCounter <= 16'h0000;
			storeWord           <= 96'h0;
			storeParity         <= 3'h0;
		end else begin
			fetch               <= request;
			microProgramCounter <= reqAddress;
			if (request && optSelect && !ctrl[2]) begin
				storeWord   <= ~96'h0;
				storeParity <= 3'h7;
			end else if (request) begin
				storeWord   <= pattern;
				storeParity <= {^pattern[95:64], ^pattern[63:32], ^pattern[31:0]} ^ badGroups;
			end else begin
				// released bus inverts every cycle, so the stale value looks valid again on every second cycle
				storeWord   <= ~storeWord;
				storeParity <= ~storeParity;
			end
		end
	end

endmodule : mwp_store_model

// *** testbench.sv ***
// self-checking bench for the microword parity error status block
`timescale 1ns/1ps
`include "mwp_consts.svh"

module testbench;
	import mwp_pkg::*;

	// ****************************************
	// signals
	// ****************************************
	typedef struct packed {
		mwp_uaddr_t adr;
		logic [2:0] bad;
		logic [2:0] ctrl;
		logic [2:0] groups;
	} mwp_row_t;

	logic           clk = 1'b0;
	logic           reset_n = 1'b0;
	logic           wbCyc = 1'b0;
	logic           wbStb = 1'b0;
	logic           wbWe = 1'b0;
	logic [7:0]     wbAdr = 8'h00;
	logic [3:0]     wbSel = 4'hF;
	logic [31:0]    wbDatIn = 32'h0;
	logic [31:0]    wbDatOut;
	logic           wbAck;
	logic           cpuInit = 1'b0;
	logic           stall = 1'b0;
	logic           arithTrapLoad = 1'b0;
	mwp_trap_code_t arithTrapCode = MWP_TRAP_NONE;
	logic           condLoad = 1'b0;
	logic [4:0]     condBits = 5'h00;
	logic           consoleStoreWrite = 1'b0;
	logic           request = 1'b0;
	mwp_uaddr_t     reqAddress = 16'h0000;
	logic [2:0]     badGroups = 3'h0;
	logic [2:0]     modelCtrl = 3'h0;
	logic           fetch;
	mwp_uaddr_t     microProgramCounter;
	mwp_word_t      storeWord;
	logic [2:0]     storeParity;
	logic           trapRequest;
	logic           translationBufferHalt;
	logic           syncTrigger;
	logic           cpuHalt;
	logic [1:0]     asyncTrapLevel;
	logic [13:0]    indicator;
	logic           storeWriteEnable;
	mwp_uaddr_t     trappedMicroAddress;
	logic [31:0]    rd;
	logic [3:0]     trapSeen;
	logic [3:0]     syncSeen;
	logic           hit;
	int             errCount = 0;
	int             checkCount = 0;
	int             cycles = 0;
	logic [7:0]     zeroRegs [3] = '{`MWP_ADDR_CTRL, `MWP_ADDR_MATCH, 8'h40};
	// address, spoiled groups, control, expected group flags
	mwp_row_t       rows [9] = '{
		'{16'h0101, 3'h0, 3'h0, 3'h0},
		'{16'h0102, 3'h1, 3'h0, 3'h1},
		'{16'h1103, 3'h2, 3'h0, 3'h2},
		'{16'h0104, 3'h4, 3'h0, 3'h4},
		'{16'h0105, 3'h5, 3'h0, 3'h5},
		'{16'h1400, 3'h0, 3'h0, 3'h7},
		'{16'h1400, 3'h0, 3'h4, 3'h0},
		'{16'h1C00, 3'h0, 3'h2, 3'h7},
		'{16'h1400, 3'h0, 3'h2, 3'h0}
	};

	mwp_error_status dut (.clk(clk), .reset_n(reset_n), .wbCyc(wbCyc), .wbStb(wbStb),
		.wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatIn(wbDatIn), .wbDatOut(wbDatOut),
		.wbAck(wbAck), .fetch(fetch), .microProgramCounter(microProgramCounter),
		.storeWord(storeWord), .storeParity(storeParity), .cpuInit(cpuInit), .stall(stall),
		.arithTrapLoad(arithTrapLoad), .arithTrapCode(arithTrapCode), .condLoad(condLoad),
		.condBits(condBits), .consoleStoreWrite(consoleStoreWrite), .trapRequest(trapRequest),
		.translationBufferHalt(translationBufferHalt), .syncTrigger(syncTrigger),
		.cpuHalt(cpuHalt), .asyncTrapLevel(asyncTrapLevel), .indicator(indicator),
		.storeWriteEnable(storeWriteEnable), .trappedMicroAddress(trappedMicroAddress));

	mwp_store_model store (.clk(clk), .reset_n(reset_n), .request(request),
		.reqAddress(reqAddress), .badGroups(badGroups), .ctrl(modelCtrl), .fetch(fetch),
		.microProgramCounter(microProgramCounter), .storeWord(storeWord),
		.storeParity(storeParity));

	// ****************************************
	// tasks
	// ****************************************
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checkCount++;
		if (got !== exp) begin
			errCount++;
			$display("ERROR at %0t ns: got %h, expected %h", $time, got, exp);
		end
	endtask : check

	task automatic giveVerdict;
		$display("checks %0d, errors %0d", checkCount, errCount);
		if (errCount == 0 && checkCount > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : giveVerdict

	// one classic cycle; read data lands in rd at the ack edge
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
		@(posedge clk);
		wbCyc   <= 1'b1;
		wbStb   <= 1'b1;
		wbWe    <= we;
		wbAdr   <= adr;
		wbDatIn <= wd;
		do
			@(posedge clk);
		while (wbAck !== 1'b1);
		rd = wbDatOut;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		wbWe  <= 1'b0;
	endtask : wb

	// one fetch, then count trap and sync pulses over a short window
	task automatic doFetch(input mwp_uaddr_t adr, input logic [2:0] bad);
		@(posedge clk);
		request    <= 1'b1;
		reqAddress <= adr;
		badGroups  <= bad;
		@(posedge clk);
		request  <= 1'b0;
		trapSeen = 4'h0;
		syncSeen = 4'h0;
		repeat (6) begin
			@(posedge clk);
			trapSeen = trapSeen + trapRequest;
			syncSeen = syncSeen + syncTrigger;
		end
		check(indicator, {stall, adr[12:0]});
	endtask : doFetch

	// ****************************************
	// clock, timeout and sequence
	// ****************************************
	always #2 clk = ~clk;

	// whole run needs a few hundred cycles; a hang stops here
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errCount++;
			giveVerdict();
		end
	end

	initial begin
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		stall   <= 1'b1;
		@(posedge clk);
		check({trappedMicroAddress, asyncTrapLevel, wbAck, trapRequest, translationBufferHalt,
			syncTrigger, cpuHalt, storeWriteEnable}, 32'h0);
		// unmapped write is ignored, reset registers read zero
		wb(1'b1, 8'h40, 32'hFFFF_FFFF);
		foreach (zeroRegs[k]) begin
			wb(1'b0, zeroRegs[k], 32'h0);
			check(rd, 32'h0);
		end
		// table of parity cases, each cleared afterwards
		foreach (rows[i]) begin
			modelCtrl <= rows[i].ctrl;
			wb(1'b1, `MWP_ADDR_CTRL, {29'h0, rows[i].ctrl});
			hit = |rows[i].groups;
			doFetch(rows[i].adr, rows[i].bad);
			check(trapSeen, {3'h0, hit});
			check(translationBufferHalt, hit);
			if (hit)
				check(trappedMicroAddress, rows[i].adr);
			doFetch(16'h0200, 3'h0);
			wb(1'b0, `MWP_ADDR_CES, 32'h0);
			check(rd[15:12], {hit, rows[i].groups});
			wb(1'b1, `MWP_ADDR_CES, 32'h0000_7000);
			wb(1'b0, `MWP_ADDR_CES, 32'h0);
			check(rd[15:12], 4'h0);
		end
		// second error keeps the first trapped address
		doFetch(16'h1234, 3'h1);
		doFetch(16'h0456, 3'h2);
		check(trappedMicroAddress, 16'h1234);
		wb(1'b0, `MWP_ADDR_TRAPPED, 32'h0);
		check(rd, 32'h0000_1234);
		wb(1'b0, `MWP_ADDR_CES, 32'h0);
		check(rd[15:12], 4'hB);
		@(posedge clk);
		cpuInit <= 1'b1;
		@(posedge clk);
		cpuInit <= 1'b0;
		wb(1'b0, `MWP_ADDR_CES, 32'h0);
		check({rd[15:12], translationBufferHalt}, 5'h00);
		// every trap code and the condition bits
		for (int c = 0; c < 8; c++) begin
			arithTrapLoad <= 1'b1;
			arithTrapCode <= mwp_trap_code_t'(c[2:0]);
			condLoad      <= 1'b1;
			condBits      <= 5'h15;
			@(posedge clk);
			arithTrapLoad <= 1'b0;
			condLoad      <= 1'b0;
			wb(1'b0, `MWP_ADDR_CES, 32'h0);
			check(rd[11:4], {5'h15, c[2:0]});
		end
		wb(1'b1, `MWP_ADDR_CES, 32'h0000_0004);
		wb(1'b0, `MWP_ADDR_CES, 32'h0);
		check({rd[2:1], asyncTrapLevel}, 4'hA);
		// stack overfilled by one, then popped past empty
		for (int k = 0; k < 9; k++)
			wb(1'b1, `MWP_ADDR_STACK, 32'h0000_0100 + k);
		for (int k = 8; k >= 0; k--) begin
			wb(1'b0, `MWP_ADDR_STACK, 32'h0);
			check(rd[15:0], k > 0 ? 32'h0000_0100 + k : 32'h0);
		end
		// match trigger with and without the stop bit
		wb(1'b1, `MWP_ADDR_MATCH, 32'h0000_0321);
		wb(1'b1, `MWP_ADDR_CTRL, 32'h0);
		doFetch(16'h0321, 3'h0);
		check({syncSeen, cpuHalt}, 5'h02);
		wb(1'b1, `MWP_ADDR_CTRL, 32'h1);
		doFetch(16'h0320, 3'h0);
		check({syncSeen, cpuHalt}, 5'h00);
		doFetch(16'h0321, 3'h0);
		check({syncSeen, cpuHalt}, 5'h03);
		wb(1'b0, `MWP_ADDR_STATUS, 32'h0);
		check(rd[0], 1'b1);
		wb(1'b1, `MWP_ADDR_CTRL, 32'h0);
		repeat (2) @(posedge clk);
		check(cpuHalt, 1'b0);
		// console write strobe reaches the store enable a cycle later
		consoleStoreWrite <= 1'b1;
		@(posedge clk);
		consoleStoreWrite <= 1'b0;
		@(posedge clk);
		check(storeWriteEnable, 1'b1);
		@(posedge clk);
		check(storeWriteEnable, 1'b0);
		giveVerdict();
	end

endmodule : testbench
